// ===== src/tap_pkg.sv
// Purpose: shared constants and types for the test access port and debug block
// Assumes: fuse and lock inputs read 1 when programmed or set
// Notes:   opcodes of the debug chains and register offsets are local choices
package tap_pkg;

	// controller states, coded 0 to 15 in the listed order
	typedef enum logic [3:0] {
		TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SHIFT_DR, TS_EXIT1_DR,
		TS_PAUSE_DR, TS_EXIT2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SHIFT_IR,
		TS_EXIT1_IR, TS_PAUSE_IR, TS_EXIT2_IR, TS_UPD_IR
	} tap_state_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} tap_pins_t;

	typedef struct packed {
		logic port_en;
		logic dbg_en;
		logic lock_one;
		logic lock_two;
	} tap_fuse_t;

	localparam int          IR_W       = 4;
	localparam int          ADDR_W     = 16;
	localparam int          NUM_BP     = 4;
	localparam int          CPU_W      = 16;
	localparam int          BSC_W_DEF  = 8;
	localparam int          TMS_RESET_CNT = 5;
	localparam logic [3:0]  IR_CAPTURE = 4'h1;

	localparam logic [3:0]  OP_EXTEST  = 4'h0;
	localparam logic [3:0]  OP_IDCODE  = 4'h1;
	localparam logic [3:0]  OP_SAMPLE  = 4'h2;
	localparam logic [3:0]  OP_DBG_BP  = 4'h8;
	localparam logic [3:0]  OP_DBG_CPU = 4'h9;
	localparam logic [3:0]  OP_BYPASS  = 4'hF;

	// arbitrary neutral identification value, bit 0 fixed at one
	localparam logic [31:0] IDCODE_DEF = 32'h0000_0001;

	// break point configurations
	localparam logic [2:0]  BP_4P      = 3'h0;
	localparam logic [2:0]  BP_3P1D    = 3'h1;
	localparam logic [2:0]  BP_2P2D    = 3'h2;
	localparam logic [2:0]  BP_2P_PRNG = 3'h3;
	localparam logic [2:0]  BP_2P_DRNG = 3'h4;

	typedef struct packed {
		logic [2:0]                    mode;
		logic                          flow_brk;
		logic                          step_brk;
		logic [NUM_BP-1:0][ADDR_W-1:0] addr;
	} tap_bp_cfg_t;

	localparam int BP_W = $bits(tap_bp_cfg_t);

	localparam logic [7:0]  OFF_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_STATUS = 8'h04;
	localparam int          CTRL_DIS_BIT = 0;

endpackage : tap_pkg

// ===== src/tap_debug_port.sv
// Purpose: test access port controller, data registers and break point unit
// Assumes: tck, tms, tdi and fuses are asynchronous, sampled by core_clk
// Notes:   tck must stay well below a quarter of core_clk
//
// Behaviour
// R1: sixteen-state controller steps on each tck rising edge using tms.
// R2: controller starts in test-logic-reset after power-on reset.
// R3: all shift paths move least significant bit in and out first.
// R4: tester walks idle to shift-ir with tms 1,1,0,0, then shifts four bits.
// R5: tester holds tms low for three low bits, high with the top bit.
// R6: instruction shift sends out captured value 0x01 on tdo.
// R7: instruction takes effect only in update-ir; tms 1,1,0 returns to idle.
// R8: current instruction picks the data path and steers its circuitry.
// R9: tester reaches shift-dr with tms 1,0,0, raises tms with last bit.
// R10: shift-dr sends out the values captured in capture-dr.
// R11: latched data outputs change only in update-dr.
// R12: exit and pause states only navigate, touching no register.
// R13: instruction and data use need not pass through idle.
// R14: five tck periods with tms high always reach test-logic-reset.
// R15: no separate test reset input exists.
// R16: port fuse unprogrammed makes pins ordinary and holds controller reset.
// R17: port fuse programmed pulls test inputs high and enables the port.
// R18: id, bypass, boundary for board test; debug chains only when debug enabled.
// R19: debug works only with both fuses programmed and no lock bit set.
// R20: debugger feeds processor instructions via the cpu scan chain.
// R21: break on flow change, single step, two program and two combined points.
// R22: four points configure as 4P, 3P+1D, 2P+2D, or 2P plus masked range.
// R23: port also needs the software disable bit cleared.
// R24: tdo driven only in shift states, updated on tck falling edge.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module tap_debug_port #(
	parameter int          BSC_W        = tap_pkg::BSC_W_DEF,
	parameter logic [31:0] IDCODE_VALUE = tap_pkg::IDCODE_DEF
) (
	input  wire logic                        core_clk,
	input  wire logic                        reset_n,
	input  wire tap_pkg::tap_pins_t          pins_in,
	input  wire tap_pkg::tap_fuse_t          fuse_in,
	output logic                             tdo,
	output logic                             tdo_oe,
	output logic                             pins_are_port,
	output logic                             tap_pullup_en,
	input  wire logic [BSC_W-1:0]            bsc_pin_in,
	output logic      [BSC_W-1:0]            bsc_pin_out,
	output logic                             bsc_drive,
	input  wire logic [7:0]                  cpu_result,
	output logic      [tap_pkg::CPU_W-1:0]   cpu_instr,
	output logic                             cpu_instr_valid,
	input  wire logic [tap_pkg::ADDR_W-1:0]  pc_addr,
	input  wire logic                        pc_valid,
	input  wire logic [tap_pkg::ADDR_W-1:0]  data_addr,
	input  wire logic                        data_valid,
	input  wire logic                        flow_change,
	input  wire logic                        step_done,
	output logic                             break_req,
	output logic                             debug_active,
	input  wire logic [7:0]                  reg_addr,
	input  wire logic [31:0]                 reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [31:0]                 reg_rdata
);

	tap_pkg::tap_pins_t    pins_s1_q, pins_s2_q;
	tap_pkg::tap_fuse_t    fuse_s1_q, fuse_s2_q;
	logic                  tck_prev_q;
	logic                  tck_rise, tck_fall;
	logic                  tap_disable_bit_q;
	logic                  tap_en, debug_ok;
	tap_pkg::tap_state_t   state_q, state_d;
	logic [3:0]            ir_sr_q, ir_q;
	logic                  byp_q;
	logic [31:0]           id_sr_q;
	logic [BSC_W-1:0]      bsc_sr_q;
	logic [tap_pkg::BP_W-1:0]  bp_sr_q;
	tap_pkg::tap_bp_cfg_t  bp_cfg_q;
	logic [tap_pkg::CPU_W-1:0] cpu_sr_q;
	logic                  sel_bp, sel_cpu;
	logic                  dr_bit;
	logic [tap_pkg::NUM_BP-1:0] bp_hit;

	// input synchronisers, first stage read only by second
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pins_s1_q  <= 3'h3;  // tck idles low, tms and tdi high
			pins_s2_q  <= 3'h3;
			fuse_s1_q  <= '0;
			fuse_s2_q  <= '0;
			tck_prev_q <= 1'b0;
		end else begin
			pins_s1_q  <= pins_in;
			pins_s2_q  <= pins_s1_q;
			fuse_s1_q  <= fuse_in;
			fuse_s2_q  <= fuse_s1_q;
			tck_prev_q <= pins_s2_q.tck;
		end
	end

	assign tck_rise = pins_s2_q.tck & ~tck_prev_q;
	assign tck_fall = ~pins_s2_q.tck & tck_prev_q;

	assign tap_en   = fuse_s2_q.port_en & ~tap_disable_bit_q;  // R16 R23
	assign debug_ok = fuse_s2_q.port_en & fuse_s2_q.dbg_en
		& ~fuse_s2_q.lock_one & ~fuse_s2_q.lock_two;  // R19
	assign sel_bp   = debug_ok & (ir_q == tap_pkg::OP_DBG_BP);  // R18
	assign sel_cpu  = debug_ok & (ir_q == tap_pkg::OP_DBG_CPU);  // R18

	// controller transitions
	always_comb begin
		state_d = state_q;
		unique case (state_q)  // R1 R13
			tap_pkg::TS_RESET:    state_d = pins_s2_q.tms ? tap_pkg::TS_RESET  : tap_pkg::TS_IDLE;
			tap_pkg::TS_IDLE:     state_d = pins_s2_q.tms ? tap_pkg::TS_SEL_DR : tap_pkg::TS_IDLE;
			tap_pkg::TS_SEL_DR:   state_d = pins_s2_q.tms ? tap_pkg::TS_SEL_IR : tap_pkg::TS_CAP_DR;
			tap_pkg::TS_CAP_DR:   state_d = pins_s2_q.tms ? tap_pkg::TS_EXIT1_DR : tap_pkg::TS_SHIFT_DR;
			tap_pkg::TS_SHIFT_DR: state_d = pins_s2_q.tms ? tap_pkg::TS_EXIT1_DR : tap_pkg::TS_SHIFT_DR;
			tap_pkg::TS_EXIT1_DR: state_d = pins_s2_q.tms ? tap_pkg::TS_UPD_DR : tap_pkg::TS_PAUSE_DR;
			tap_pkg::TS_PAUSE_DR: state_d = pins_s2_q.tms ? tap_pkg::TS_EXIT2_DR : tap_pkg::TS_PAUSE_DR;
			tap_pkg::TS_EXIT2_DR: state_d = pins_s2_q.tms ? tap_pkg::TS_UPD_DR : tap_pkg::TS_SHIFT_DR;
			tap_pkg::TS_UPD_DR:   state_d = pins_s2_q.tms ? tap_pkg::TS_SEL_DR : tap_pkg::TS_IDLE;
			tap_pkg::TS_SEL_IR:   state_d = pins_s2_q.tms ? tap_pkg::TS_RESET  : tap_pkg::TS_CAP_IR;
			tap_pkg::TS_CAP_IR:   state_d = pins_s2_q.tms ? tap_pkg::TS_EXIT1_IR : tap_pkg::TS_SHIFT_IR;
			tap_pkg::TS_SHIFT_IR: state_d = pins_s2_q.tms ? tap_pkg::TS_EXIT1_IR : tap_pkg::TS_SHIFT_IR;
			tap_pkg::TS_EXIT1_IR: state_d = pins_s2_q.tms ? tap_pkg::TS_UPD_IR : tap_pkg::TS_PAUSE_IR;
			tap_pkg::TS_PAUSE_IR: state_d = pins_s2_q.tms ? tap_pkg::TS_EXIT2_IR : tap_pkg::TS_PAUSE_IR;
			tap_pkg::TS_EXIT2_IR: state_d = pins_s2_q.tms ? tap_pkg::TS_UPD_IR : tap_pkg::TS_SHIFT_IR;
			tap_pkg::TS_UPD_IR:   state_d = pins_s2_q.tms ? tap_pkg::TS_SEL_DR : tap_pkg::TS_IDLE;
		endcase
	end

	// no test reset pin: only reset_n, tms or the enables reset it
	always_ff @(posedge core_clk) begin
		if (!reset_n || !tap_en) begin  // R2 R15 R16 R23
			state_q <= tap_pkg::TS_RESET;
		end else if (tck_rise) begin
			state_q <= state_d;  // R14
		end
	end

	// instruction path
	always_ff @(posedge core_clk) begin
		if (!reset_n || state_q == tap_pkg::TS_RESET) begin
			ir_sr_q <= tap_pkg::IR_CAPTURE;
			ir_q    <= tap_pkg::OP_IDCODE;
		end else if (tck_rise) begin
			unique case (state_q)
				tap_pkg::TS_CAP_IR:   ir_sr_q <= tap_pkg::IR_CAPTURE;  // R6
				tap_pkg::TS_SHIFT_IR: ir_sr_q <= {pins_s2_q.tdi, ir_sr_q[3:1]};  // R3
				tap_pkg::TS_UPD_IR:   ir_q    <= ir_sr_q;  // R7
				default:              ir_sr_q <= ir_sr_q;  // R12
			endcase
		end
	end

	// data path capture into every chain, shift selected by instruction
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			byp_q    <= 1'b0;
			id_sr_q  <= '0;
			bsc_sr_q <= '0;
			bp_sr_q  <= '0;
			cpu_sr_q <= '0;
		end else if (tck_rise && state_q == tap_pkg::TS_CAP_DR) begin  // R10
			byp_q    <= 1'b0;
			id_sr_q  <= IDCODE_VALUE;
			bsc_sr_q <= bsc_pin_in;
			bp_sr_q  <= bp_cfg_q;
			cpu_sr_q <= {8'h00, cpu_result};  // R20
		end else if (tck_rise && state_q == tap_pkg::TS_SHIFT_DR) begin  // R8 R3
			if (sel_bp) begin
				bp_sr_q <= {pins_s2_q.tdi, bp_sr_q[tap_pkg::BP_W-1:1]};
			end else if (sel_cpu) begin
				cpu_sr_q <= {pins_s2_q.tdi, cpu_sr_q[tap_pkg::CPU_W-1:1]};
			end else begin
				unique case (ir_q)
					tap_pkg::OP_IDCODE: id_sr_q <= {pins_s2_q.tdi, id_sr_q[31:1]};
					tap_pkg::OP_EXTEST,
					tap_pkg::OP_SAMPLE: bsc_sr_q <= {pins_s2_q.tdi, bsc_sr_q[BSC_W-1:1]};
					default:            byp_q <= pins_s2_q.tdi;
				endcase
			end
		end
	end

	always_comb begin
		dr_bit = byp_q;
		if (sel_bp) begin
			dr_bit = bp_sr_q[0];
		end else if (sel_cpu) begin
			dr_bit = cpu_sr_q[0];
		end else if (ir_q == tap_pkg::OP_IDCODE) begin
			dr_bit = id_sr_q[0];
		end else if (ir_q == tap_pkg::OP_EXTEST || ir_q == tap_pkg::OP_SAMPLE) begin
			dr_bit = bsc_sr_q[0];
		end
	end

	// latched data outputs
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			bsc_pin_out     <= '0;
			bp_cfg_q        <= '0;
			cpu_instr       <= '0;
			cpu_instr_valid <= 1'b0;
		end else begin
			cpu_instr_valid <= 1'b0;
			if (tck_rise && state_q == tap_pkg::TS_UPD_DR) begin  // R11
				if (ir_q == tap_pkg::OP_EXTEST || ir_q == tap_pkg::OP_SAMPLE) begin
					bsc_pin_out <= bsc_sr_q;
				end
				if (sel_bp) begin
					bp_cfg_q <= bp_sr_q;
				end
				if (sel_cpu) begin
					cpu_instr       <= cpu_sr_q;  // R20
					cpu_instr_valid <= 1'b1;
				end
			end
		end
	end

	// tdo on falling edge, enabled in shift states only
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (!tap_en) begin
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin  // R24
			tdo    <= (state_q == tap_pkg::TS_SHIFT_IR) ? ir_sr_q[0] : dr_bit;
			tdo_oe <= state_q == tap_pkg::TS_SHIFT_IR || state_q == tap_pkg::TS_SHIFT_DR;
		end
	end

	// pin mode, pull-ups, boundary drive
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pins_are_port <= 1'b1;
			tap_pullup_en <= 1'b0;
			bsc_drive     <= 1'b0;
			debug_active  <= 1'b0;
		end else begin
			pins_are_port <= ~fuse_s2_q.port_en;  // R16
			tap_pullup_en <= fuse_s2_q.port_en;  // R17
			bsc_drive     <= tap_en && ir_q == tap_pkg::OP_EXTEST;  // R8
			debug_active  <= debug_ok & tap_en;  // R19
		end
	end

	// break point match; mask of a range sits in the fourth address slot
	function automatic logic bp_match(input tap_pkg::tap_bp_cfg_t cfg, input int idx,
		input logic [tap_pkg::ADDR_W-1:0] pa, input logic pv,
		input logic [tap_pkg::ADDR_W-1:0] da, input logic dv);
		logic                      is_data;
		logic                      is_rng;
		logic [tap_pkg::ADDR_W-1:0] mask;
		is_data = (cfg.mode == tap_pkg::BP_3P1D && idx == 3)
			|| (cfg.mode == tap_pkg::BP_2P2D && idx >= 2)
			|| (cfg.mode == tap_pkg::BP_2P_DRNG && idx == 2);
		is_rng  = (cfg.mode == tap_pkg::BP_2P_PRNG || cfg.mode == tap_pkg::BP_2P_DRNG) && idx == 2;
		mask    = is_rng ? cfg.addr[3] : '0;
		if ((cfg.mode == tap_pkg::BP_2P_PRNG || cfg.mode == tap_pkg::BP_2P_DRNG) && idx == 3) begin
			bp_match = 1'b0;
		end else if (is_data) begin
			bp_match = dv && ((da & ~mask) == (cfg.addr[idx] & ~mask));
		end else begin
			bp_match = pv && ((pa & ~mask) == (cfg.addr[idx] & ~mask));
		end
	endfunction : bp_match

	for (genvar g = 0; g < tap_pkg::NUM_BP; g++) begin : g_bp
		assign bp_hit[g] = bp_match(bp_cfg_q, g, pc_addr, pc_valid, data_addr, data_valid);  // R22
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			break_req <= 1'b0;
		end else begin
			break_req <= debug_ok && (|bp_hit || (bp_cfg_q.flow_brk && flow_change)
				|| (bp_cfg_q.step_brk && step_done));  // R21 R19
		end
	end

	// register port
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			tap_disable_bit_q <= 1'b0;
		end else if (reg_wr && reg_addr == tap_pkg::OFF_CTRL) begin
			tap_disable_bit_q <= reg_wdata[tap_pkg::CTRL_DIS_BIT];  // R23
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n || !reg_rd) begin
			reg_rdata <= '0;
		end else begin
			unique case (reg_addr)
				tap_pkg::OFF_CTRL:   reg_rdata <= {31'h0, tap_disable_bit_q};
				tap_pkg::OFF_STATUS: reg_rdata <= {22'h0, tap_en, debug_ok, ir_q, 4'(state_q)};
				default:             reg_rdata <= '0;
			endcase
		end
	end

	// checks
	logic [2:0] tms_high_cnt_q;
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			tms_high_cnt_q <= '0;
		end else if (tck_rise) begin
			tms_high_cnt_q <= !pins_s2_q.tms ? 3'h0 : (tms_high_cnt_q == 3'h7) ? 3'h7
				: tms_high_cnt_q + 3'h1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	chk_five_tms_reset: assert property (tms_high_cnt_q >= 3'(tap_pkg::TMS_RESET_CNT)
		|-> state_q == tap_pkg::TS_RESET) else $error("five tms high did not reset");  // R14
	chk_disabled_held: assert property (!tap_en |=> state_q == tap_pkg::TS_RESET
		&& !tdo_oe) else $error("disabled port not held in reset");  // R16
	chk_ir_capture_val: assert property (tck_rise && state_q == tap_pkg::TS_CAP_IR
		|=> ir_sr_q == 4'h1) else $error("ir capture value wrong");  // R6
	chk_ir_update_only: assert property ($changed(ir_q) |-> $past(state_q) == tap_pkg::TS_UPD_IR
		|| $past(state_q) == tap_pkg::TS_RESET) else $error("ir changed outside update");  // R7
	chk_ir_lsb_first: assert property (tck_rise && state_q == tap_pkg::TS_SHIFT_IR
		|=> ir_sr_q[3] == $past(pins_s2_q.tdi) && ir_sr_q[2:0] == $past(ir_sr_q[3:1]))
		else $error("ir shift order wrong");  // R3
	chk_tdo_enable: assert property (tap_en && tck_fall |=> tdo_oe == ($past(state_q)
		== tap_pkg::TS_SHIFT_IR || $past(state_q) == tap_pkg::TS_SHIFT_DR))
		else $error("tdo enable outside shift");  // R24
	chk_bsc_update_dr: assert property ($changed(bsc_pin_out) |-> $past(tck_rise)
		&& $past(state_q) == tap_pkg::TS_UPD_DR) else $error("boundary out changed early");  // R11
	chk_cpu_chain_gate: assert property ($rose(cpu_instr_valid) |-> $past(debug_ok)
		&& $past(state_q) == tap_pkg::TS_UPD_DR) else $error("cpu instr without debug");  // R19
	chk_break_gate: assert property (break_req |-> $past(debug_ok))
		else $error("break while debug disabled");  // R19
	chk_bypass_capture: assert property (tck_rise && state_q == tap_pkg::TS_CAP_DR
		|=> !byp_q) else $error("bypass not cleared on capture");  // R10

	cov_ir_update: cover property (tck_rise && state_q == tap_pkg::TS_UPD_IR);
	cov_dr_pause: cover property (tck_rise && state_q == tap_pkg::TS_PAUSE_DR);
	cov_cpu_instr: cover property (cpu_instr_valid);
	cov_break: cover property (break_req);

endmodule : tap_debug_port

// ===== bench/tap_tester.sv
// Purpose: tester model that drives the four-wire test link
// Assumes: core_clk at 4 ns; tck period 31 cycles, every fourth 32: 125 ns mean
// Notes:   tdo taken just before each tck rise; tck rests low between frames
//          a released tdo reads inverted, so an idle output shows as wrong data
`timescale 1ns/1ps
module tap_tester (
	input  wire logic          core_clk,
	input  wire logic          tdo,
	input  wire logic          tdo_oe,
	output tap_pkg::tap_pins_t pins
);
	int n_step = 0;

	// idle inputs rest at the pulled-up level
	initial pins = 3'b011;

	task automatic step(input logic tms, input logic tdi, output logic seen);
		@(posedge core_clk);
		pins.tms <= tms;
		pins.tdi <= tdi;
		repeat (15) @(posedge core_clk);
		seen = tdo_oe ? tdo : !tdo;
		pins.tck <= 1'b1;
		repeat (15 + int'(n_step % 4 == 3)) @(posedge core_clk);
		pins.tck <= 1'b0;
		n_step++;
	endtask : step

	task automatic nav(input logic [7:0] seq, input int n);
		logic s;
		for (int i = 0; i < n; i++) begin
			step(seq[i], 1'b1, s);
		end
	endtask : nav

	// lsb first; tms rises with the last bit so the shift state is left
	task automatic shift(input logic [127:0] din, input int n, output logic [127:0] dout);
		logic s;
		dout = '0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], s);
			dout[i] = s;
		end
	endtask : shift

	// from idle or an update state; ends in exit1 of the chosen branch
	task automatic scan(input logic ir, input logic [127:0] din, input int n,
			output logic [127:0] dout);
		nav(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
		shift(din, n, dout);
	endtask : scan
endmodule : tap_tester

// ===== bench/jtag_tap_debug_access_test.sv
// Purpose: self-checking bench for the test access port and debug block
// Assumes: fuses programmed at start; boundary chain 8 bits
// Notes:   all stimulus changes right after a core_clk rise
`timescale 1ns/1ps
module jtag_tap_debug_access_test;
	// arbitrary identification value, bit 0 set
	localparam logic [31:0] ID_VAL = 32'h0A5C_3E71;
	logic               core_clk, reset_n, tdo, tdo_oe, pins_are_port, tap_pullup_en;
	logic               bsc_drive, cpu_instr_valid, pc_valid, data_valid, flow_change;
	logic               step_done, break_req, debug_active, reg_wr, reg_rd;
	logic [7:0]         bsc_in, bsc_out, cpu_result, reg_addr;
	logic [15:0]        cpu_instr, pc_addr, data_addr;
	logic [31:0]        reg_wdata, reg_rdata;
	logic [127:0]       d;
	tap_pkg::tap_pins_t pins;
	tap_pkg::tap_fuse_t fuse;
	int                 err_count, checks_done, pulses;

	tap_tester tst (.core_clk(core_clk), .tdo(tdo), .tdo_oe(tdo_oe), .pins(pins));

	tap_debug_port #(.BSC_W(8), .IDCODE_VALUE(ID_VAL)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .pins_in(pins), .fuse_in(fuse),
		.tdo(tdo), .tdo_oe(tdo_oe), .pins_are_port(pins_are_port),
		.tap_pullup_en(tap_pullup_en), .bsc_pin_in(bsc_in), .bsc_pin_out(bsc_out),
		.bsc_drive(bsc_drive), .cpu_result(cpu_result), .cpu_instr(cpu_instr),
		.cpu_instr_valid(cpu_instr_valid), .pc_addr(pc_addr), .pc_valid(pc_valid),
		.data_addr(data_addr), .data_valid(data_valid), .flow_change(flow_change),
		.step_done(step_done), .break_req(break_req), .debug_active(debug_active),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata)
	);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	always @(posedge core_clk) if (cpu_instr_valid === 1'b1) pulses++;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1 v = reg_rdata;
	endtask : reg_read

	task automatic status(input logic dbg, input logic [3:0] ir, input logic [3:0] st,
			input string what);
		logic [31:0] v;
		reg_read(tap_pkg::OFF_STATUS, v);
		check(v, {22'h0, 1'b1, dbg, ir, st}, what);
	endtask : status

	task automatic ir_go(input logic [3:0] op);
		tst.scan(1'b1, {124'h0, op}, 4, d);
		tst.nav(8'h01, 2);
	endtask : ir_go

	task automatic probe(input int k, input logic [15:0] a, input logic e);
		@(posedge core_clk);
		pc_addr     <= a;
		data_addr   <= a;
		pc_valid    <= (k == 0);
		data_valid  <= (k == 1);
		flow_change <= (k == 2);
		step_done   <= (k == 3);
		@(posedge core_clk);
		{pc_valid, data_valid, flow_change, step_done} <= 4'h0;
		#1 check(break_req, e, "break");
	endtask : probe

	task automatic t_basic;
		logic [31:0] v;
		status(1'b1, tap_pkg::OP_IDCODE, tap_pkg::TS_RESET, "after reset");
		check(pins_are_port, 1'b0, "port pins");
		check(tap_pullup_en, 1'b1, "pullups");
		check(tdo_oe, 1'b0, "tdo idle");
		reg_read(8'h08, v);
		check(v, 32'h0, "unmapped read");
		tst.nav(8'h00, 1);
		status(1'b1, tap_pkg::OP_IDCODE, tap_pkg::TS_IDLE, "idle");
		tst.scan(1'b0, 128'h0, 32, d);
		check(d[31:0], ID_VAL, "id capture");
		tst.nav(8'h01, 2);
		$display("test basic done");
	endtask : t_basic

	task automatic t_ir;
		tst.scan(1'b1, {124'h0, tap_pkg::OP_BYPASS}, 4, d);
		check(d[3:0], 4'h1, "ir capture");
		status(1'b1, tap_pkg::OP_IDCODE, tap_pkg::TS_EXIT1_IR, "exit1 ir");
		tst.nav(8'h00, 1);
		status(1'b1, tap_pkg::OP_IDCODE, tap_pkg::TS_PAUSE_IR, "pause ir");
		tst.nav(8'h03, 2);
		status(1'b1, tap_pkg::OP_IDCODE, tap_pkg::TS_UPD_IR, "update ir");
		tst.scan(1'b0, 128'hB6, 8, d);
		check(d[7:0], 8'h6C, "bypass delay");
		tst.nav(8'h01, 2);
		$display("test ir done");
	endtask : t_ir

	task automatic t_bsc;
		ir_go(tap_pkg::OP_SAMPLE);
		bsc_in <= 8'hA5;
		tst.scan(1'b0, 128'h3C, 8, d);
		check(d[7:0], 8'hA5, "boundary capture");
		check(bsc_out, 8'h00, "latch before update");
		tst.nav(8'h01, 2);
		check(bsc_out, 8'h3C, "latch after update");
		check(bsc_drive, 1'b0, "sample no drive");
		ir_go(tap_pkg::OP_EXTEST);
		check(bsc_drive, 1'b1, "extest drive");
		ir_go(tap_pkg::OP_BYPASS);
		tst.nav(8'h01, 3);
		repeat (6) @(posedge core_clk);
		#1 check(tdo_oe, 1'b1, "tdo in shift");
		tst.nav(8'h0F, 4);
		status(1'b1, tap_pkg::OP_BYPASS, tap_pkg::TS_SEL_IR, "four highs");
		tst.nav(8'h01, 1);
		status(1'b1, tap_pkg::OP_IDCODE, tap_pkg::TS_RESET, "five highs");
		$display("test boundary done");
	endtask : t_bsc

	task automatic t_gate;
		logic [31:0] v;
		logic [3:0]  tbl [5] = '{4'b1100, 4'b1000, 4'b1110, 4'b1101, 4'b0100};
		reg_write(tap_pkg::OFF_CTRL, 32'h1);
		reg_read(tap_pkg::OFF_CTRL, v);
		check(v, 32'h1, "disable readback");
		tst.nav(8'h03, 4);
		reg_read(tap_pkg::OFF_STATUS, v);
		check({v[9], v[3:0]}, 5'h0, "held in reset");
		check(tdo_oe, 1'b0, "tdo off");
		reg_write(tap_pkg::OFF_CTRL, 32'h0);
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk);
			fuse <= tbl[i];
			repeat (8) @(posedge core_clk);
			#1 check(debug_active, i == 0, "debug gate");
			check(pins_are_port, !tbl[i][3], "port pins");
			check(tap_pullup_en, tbl[i][3], "pullups");
		end
		@(posedge core_clk);
		fuse <= 4'b1100;
		repeat (8) @(posedge core_clk);
		tst.nav(8'h00, 1);
		$display("test gating done");
	endtask : t_gate

	task automatic t_debug;
		tap_pkg::tap_bp_cfg_t cfg;
		logic [15:0] pa [5] = '{16'h0300, 16'h0300, 16'h0200, 16'h0205, 16'h0205};
		logic        pe [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
		int          base;
		for (int m = 0; m < 5; m++) begin
			cfg.mode     = 3'(m);
			cfg.flow_brk = m[0];
			cfg.step_brk = !m[0];
			cfg.addr     = {(m > 2) ? 16'h000F : 16'h0300, 16'h0200, 16'h0020, 16'h0010};
			ir_go(tap_pkg::OP_DBG_BP);
			tst.scan(1'b0, {59'h0, cfg}, tap_pkg::BP_W, d);
			tst.nav(8'h01, 2);
			probe(0, pa[m], pe[m]);
			probe(1, pa[m], !pe[m]);
			probe(2, 16'h0, m[0]);
			probe(3, 16'h0, !m[0]);
		end
		ir_go(tap_pkg::OP_DBG_CPU);
		base = pulses;
		tst.scan(1'b0, 128'hABCD, 16, d);
		check(d[7:0], 8'h5A, "result capture");
		check(pulses - base, 0, "no early issue");
		tst.nav(8'h01, 2);
		check(cpu_instr, 16'hABCD, "instruction");
		check(pulses - base, 1, "one issue");
		$display("test debug done");
	endtask : t_debug

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	initial begin
		reset_n = 1'b0;
		fuse = 4'b1100;
		bsc_in = 8'h00;
		cpu_result = 8'h5A;
		{pc_valid, data_valid, flow_change, step_done, reg_wr, reg_rd} = 6'h0;
		{pc_addr, data_addr, reg_addr, reg_wdata} = 72'h0;
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		t_basic();
		t_ir();
		t_bsc();
		t_gate();
		t_debug();
		print_verdict();
	end

	initial begin
		#300000;
		err_count++;
		$display("ERROR at %0t: watchdog expired", $time);
		print_verdict();
	end
endmodule : jtag_tap_debug_access_test
